// ==== logic/cbc_host.sv ====
// host end of the serial control bus with complementary check bytes
// assumes master/slave mode: host outputs on out line, device inputs on in line,
// both open drain and active low (a pulled line carries a 1)
//
// Overview of operation
// - protected bytes sit on byte bounds inside words starting at multiples of 32
// - the word starting at address 0 is never protected
// - each check byte travels sixteen addresses above its data byte
// - with any checking on, channel bits inverted go out on outputs 5 to 8
// - unprotected bytes and their check slots carry ordinary data
// - check byte is data xor encoding byte; xor again recovers data
// - encoding byte is address code above, inverted channel xor direction below
// - address codes count 1 to 14 across the protected byte positions
// - channel code is the inverted multiplex channel number
// - direction code 1000 for master/slave outputs, 0000 otherwise
// - all bits are serialised least significant bit first
// - lowest address carries the lsb, highest the msb
// - a sign bit sits in the msb of its value
// - a multi-bit value is sent whole within one frame
// - addresses 0 to 15 carry system signals only
// - multiplexed signals start on multiples of 16
// - channel number goes out on outputs 1 to 4, lsb on output 1
// - data changes on the rising clock edge, sampled on the falling edge
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module cbc_host #(
    parameter int HALF_CYCLES = cbc_pkg::HALF_CYC,
    parameter int SYNC_CYCLES = cbc_pkg::SYNC_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [8:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // bus pins
    output logic             bus_clk_o,
    output logic             out_line_o,
    output logic             out_line_oe,
    input  wire logic        in_line_i
);
    import cbc_pkg::*;

    cbc_if tim ();

    logic         run_q;
    logic         auto_q;
    logic [3:0]   chan_q;
    logic [3:0]   fchan_q;
    logic [13:0]  chk_en_q;
    logic [6:0]   pair_q;
    logic [255:0] out_img_q;
    logic [255:0] out_sh_q;
    logic [255:0] in_img_q;
    logic [255:0] rx_q;
    logic [13:0]  ok_q;
    logic [13:0]  rej_q;
    logic         err_q;
    logic         done_q;
    logic         out_bit_q;
    logic [7:0]   tx_addr_q;
    logic         in_s1_q;
    logic         in_s2_q;
    logic [1:0]   samp_q;
    logic [7:0]   sa0_q;
    logic [7:0]   sa1_q;
    logic [31:0]  rdata_q;

    // ****************************************
    // bus clock and frame timing
    // ****************************************
    cbc_clkgen #(
        .HALF_CYCLES (HALF_CYCLES),
        .SYNC_CYCLES (SYNC_CYCLES)
    ) u_gen (
        .clk       (clk),
        .rst       (rst),
        .run       (run_q),
        .bus_clk_o (bus_clk_o),
        .tim       (tim)
    );

    // ****************************************
    // transmit path
    // ****************************************
    logic [4:0] tx_b;
    logic [3:0] tx_idx;
    logic [7:0] tx_chk;
    logic       tx_chk_slot;
    logic       tx_bit;

    assign tx_b        = tim.addr[7:3];
    assign tx_idx      = cbc_idx(tx_b);
    assign tx_chk_slot = cbc_is_chk(tx_b) && chk_en_q[tx_idx];

    cbc_codec u_tx (
        .d    (out_sh_q[{tx_b - CHK_BYTES, 3'h0} +: 8]),
        .idx  (tx_idx),
        .chan (fchan_q),
        .dir  (DIR_MS_OUT),
        .chk  (tx_chk)
    );

    // system slots first, then check slots, then the frame's data image
    always_comb begin
        tx_bit = 1'b0;
        if (tim.addr >= ADDR_CHAN && tim.addr < ADDR_INV) begin
            tx_bit = fchan_q[2'(tim.addr - ADDR_CHAN)];
        end else if (tim.addr >= ADDR_INV && tim.addr < ADDR_ERR_IN) begin
            tx_bit = (|chk_en_q) && !fchan_q[2'(tim.addr - ADDR_INV)];
        end else if (tim.addr >= ADDR_DATA) begin
            if (tx_chk_slot) begin
                tx_bit = tx_chk[tim.addr[2:0]];
            end else begin
                tx_bit = out_sh_q[tim.addr];
            end
        end
    end

    // the line changes only right after a rising bus clock edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_bit_q <= 1'b0;
            tx_addr_q <= ADDR_FIRST;
        end else if (tim.rise) begin
            out_bit_q <= tx_bit;
            tx_addr_q <= tim.addr;
        end
    end

    // open drain: a 1 pulls the line low, a 0 releases it
    assign out_line_o  = 1'b0;
    assign out_line_oe = out_bit_q;

    // frame copy of the output image and channel; software writes land
    // between frames only, so a value never splits across two frames
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_sh_q <= '0;
            fchan_q  <= 4'h0;
        end else if (tim.frame_start) begin
            out_sh_q <= out_img_q;
            fchan_q  <= chan_q;
        end
    end

    // ****************************************
    // receive path
    // ****************************************
    // two flops on the pin, and the sample strobe delayed to match them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_s1_q <= 1'b1;
            in_s2_q <= 1'b1;
            samp_q  <= 2'b00;
            sa0_q   <= ADDR_FIRST;
            sa1_q   <= ADDR_FIRST;
        end else begin
            in_s1_q <= in_line_i;
            in_s2_q <= in_s1_q;
            samp_q  <= {samp_q[0], tim.fall};
            sa0_q   <= tim.addr;
            sa1_q   <= sa0_q;
        end
    end

    logic       rx_bit;
    logic       rx_samp;
    logic [4:0] rx_b;
    logic [3:0] rx_idx;
    logic [7:0] rx_chk;
    logic [7:0] rx_got;

    assign rx_bit  = !in_s2_q;
    assign rx_samp = samp_q[1];
    assign rx_b    = sa1_q[7:3];
    assign rx_idx  = cbc_idx(rx_b);
    assign rx_got  = {rx_bit, rx_q[{rx_b, 3'h0} +: 7]};

    cbc_codec u_rx (
        .d    (rx_q[{rx_b - CHK_BYTES, 3'h0} +: 8]),
        .idx  (rx_idx),
        .chan (fchan_q),
        .dir  (DIR_MS_IN),
        .chk  (rx_chk)
    );

    // frame buffer and per-slot verdicts; verdicts cleared at every frame start, buffer only by reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_q <= '0;
            ok_q <= '0;
        end else if (tim.frame_start) begin
            ok_q <= '0;
        end else if (rx_samp) begin
            rx_q[sa1_q] <= rx_bit;
            if (sa1_q[2:0] == BIT_LAST && cbc_is_chk(rx_b)) begin
                ok_q[rx_idx] <= (rx_got == rx_chk);
            end
        end
    end

    // a bad byte rejects its paired partner as well
    logic [13:0] rej_now;
    always_comb begin
        rej_now = '0;
        for (int p = 0; p < NUM_PROT; p++) begin
            rej_now[p] = chk_en_q[p] && (!ok_q[p] ||
                         (pair_q[p / 2] && !ok_q[p ^ 1]));
        end
    end

    // commit whole bytes at frame end; rejected bytes keep their old value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_img_q <= '0;
        end else if (tim.frame_end) begin
            for (int i = 0; i < FRAME_ADDRS / 8; i++) begin
                if (!(cbc_is_data(5'(i)) && rej_now[cbc_idx(5'(i))])) begin
                    in_img_q[i * 8 +: 8] <= rx_q[i * 8 +: 8];
                end
            end
        end
    end

    // ****************************************
    // register port
    // ****************************************
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_rej;
    logic       wr_out;
    logic [4:0] r_word;

    assign r_word  = reg_addr[6:2];
    assign wr_ctrl = reg_wr && reg_addr == REG_CTRL;
    assign wr_stat = reg_wr && reg_addr == REG_STAT;
    assign wr_rej  = reg_wr && reg_addr == REG_REJ;
    assign wr_out  = reg_wr && reg_addr[8:7] == WIN_OUT && reg_addr[1:0] == 2'h0;

    // configuration; auto mode steps the channel once per frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q    <= 1'b0;
            auto_q   <= 1'b0;
            chan_q   <= 4'h0;
            chk_en_q <= '0;
            pair_q   <= '0;
        end else begin
            if (wr_ctrl) begin
                run_q  <= reg_wdata[CTRL_RUN];
                auto_q <= reg_wdata[CTRL_AUTO];
            end
            if (reg_wr && reg_addr == REG_CHAN) begin
                chan_q <= reg_wdata[3:0];
            end else if (tim.frame_end && auto_q) begin
                chan_q <= chan_q + 4'h1;
            end
            if (reg_wr && reg_addr == REG_CHK_EN) begin
                chk_en_q <= reg_wdata[NUM_PROT-1:0];
            end
            if (reg_wr && reg_addr == REG_PAIR) begin
                pair_q <= reg_wdata[NUM_PAIR-1:0];
            end
        end
    end

    // output image written a byte at a time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_img_q <= '0;
        end else if (wr_out) begin
            out_img_q[{r_word, 3'h0} +: 8] <= reg_wdata[7:0];
        end
    end

    // sticky flags cleared by writing one; a new event beats the clear.
    // input 9 is shared, so it cannot tell which device complained
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_q  <= 1'b0;
            done_q <= 1'b0;
            rej_q  <= '0;
        end else begin
            err_q  <= (err_q && !(wr_stat && reg_wdata[STAT_ERR]))
                      || (rx_samp && sa1_q == ADDR_ERR_IN && rx_bit);
            done_q <= (done_q && !(wr_stat && reg_wdata[STAT_DONE])) || tim.frame_end;
            rej_q  <= (rej_q & ~(wr_rej ? reg_wdata[NUM_PROT-1:0] : 14'h0000))
                      | (tim.frame_end ? rej_now : 14'h0000);
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            if (reg_rd && reg_addr[1:0] == 2'h0) begin
                unique case (reg_addr[8:7])
                    WIN_OUT: rdata_q <= {24'h000000, out_img_q[{r_word, 3'h0} +: 8]};
                    WIN_IN:  rdata_q <= {24'h000000, in_img_q[{r_word, 3'h0} +: 8]};
                    2'h0: begin
                        case (reg_addr)
                            REG_CTRL:   rdata_q <= {30'h0, auto_q, run_q};
                            REG_STAT:   rdata_q <= {20'h0, fchan_q, 5'h00, tim.busy,
                                                    done_q, err_q};
                            REG_CHAN:   rdata_q <= {28'h0, chan_q};
                            REG_CHK_EN: rdata_q <= {18'h0, chk_en_q};
                            REG_PAIR:   rdata_q <= {25'h0, pair_q};
                            REG_REJ:    rdata_q <= {18'h0, rej_q};
                            default:    rdata_q <= '0;
                        endcase
                    end
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************
    // checks
    // ****************************************
    addr0_quiet_a: assert property (@(posedge clk) disable iff (rst)
        tim.rise && tim.addr == ADDR_FIRST |=> !out_bit_q)
        else $error("address 0 carried data");

    sys_quiet_a: assert property (@(posedge clk) disable iff (rst)
        tim.rise && tim.addr >= ADDR_ERR_IN && tim.addr < ADDR_DATA |=> !out_bit_q)
        else $error("system slot above 8 not zero");

    chan_drive_a: assert property (@(posedge clk) disable iff (rst)
        tim.rise && tim.addr >= ADDR_CHAN && tim.addr < ADDR_INV
        |=> out_bit_q == fchan_q[2'(tx_addr_q - ADDR_CHAN)])
        else $error("channel bit wrong");

    chan_invert_a: assert property (@(posedge clk) disable iff (rst)
        tim.rise && tim.addr >= ADDR_INV && tim.addr < ADDR_ERR_IN
        |=> out_bit_q == ((|chk_en_q) && !fchan_q[2'(tx_addr_q - ADDR_INV)]))
        else $error("inverted channel bit wrong");

    check_bit_a: assert property (@(posedge clk) disable iff (rst)
        tim.rise && tx_chk_slot
        |=> out_bit_q == |((out_sh_q[{tx_addr_q[7:3] - CHK_BYTES, 3'h0} +: 8]
            ^ {cbc_idx(tx_addr_q[7:3]) + 4'h1, ~fchan_q ^ DIR_MS_OUT})
            & (8'h01 << tx_addr_q[2:0])))
        else $error("check bit wrong");

    plain_data_a: assert property (@(posedge clk) disable iff (rst)
        tim.rise && tim.addr >= ADDR_DATA && !tx_chk_slot
        |=> out_bit_q == out_sh_q[tx_addr_q])
        else $error("data bit wrong");

    prot_place_a: assert property (@(posedge clk) disable iff (rst)
        tx_chk_slot |-> tim.addr[4] && tim.addr[7:5] != 3'h0)
        else $error("check slot outside a protected word");

    edge_drive_a: assert property (@(posedge clk) disable iff (rst)
        $changed(out_line_oe) |-> $past(tim.rise, 1) && bus_clk_o)
        else $error("data changed away from rising edge");

    frame_hold_a: assert property (@(posedge clk) disable iff (rst)
        $changed(out_sh_q) |-> $past(tim.frame_start))
        else $error("output copy changed inside a frame");
endmodule

// ==== common/cbc_pkg.sv ====
// constants, types and helpers for the check-byte codec host
// assumes a 50 MHz system clock and a 256-address bus frame
package cbc_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS     = 20;
    localparam int BUS_CLK_NS = 160;
    localparam int HALF_CYC   = (BUS_CLK_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_NS    = 4000;
    localparam int SYNC_CYC   = (SYNC_NS + CLK_NS - 1) / CLK_NS;

    // ****************************************
    // frame layout
    // ****************************************
    localparam int          FRAME_ADDRS = 256;
    localparam int          NUM_PROT    = 14;
    localparam int          NUM_PAIR    = 7;
    localparam logic [7:0]  ADDR_LAST   = 8'hFF;
    localparam logic [7:0]  ADDR_FIRST  = 8'h00;
    localparam logic [7:0]  ADDR_CHAN   = 8'h01;
    localparam logic [7:0]  ADDR_INV    = 8'h05;
    localparam logic [7:0]  ADDR_ERR_IN = 8'h09;
    localparam logic [7:0]  ADDR_DATA   = 8'h10;
    localparam logic [4:0]  CHK_BYTES   = 5'h02;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    localparam logic [3:0]  DIR_MS_OUT  = 4'h8;
    localparam logic [3:0]  DIR_MS_IN   = 4'h0;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [8:0]  REG_CTRL   = 9'h000;
    localparam logic [8:0]  REG_STAT   = 9'h004;
    localparam logic [8:0]  REG_CHAN   = 9'h008;
    localparam logic [8:0]  REG_CHK_EN = 9'h00C;
    localparam logic [8:0]  REG_PAIR   = 9'h010;
    localparam logic [8:0]  REG_REJ    = 9'h014;
    localparam logic [1:0]  WIN_OUT    = 2'h1;
    localparam logic [1:0]  WIN_IN     = 2'h2;
    localparam int          CTRL_RUN   = 0;
    localparam int          CTRL_AUTO  = 1;
    localparam int          STAT_ERR   = 0;
    localparam int          STAT_DONE  = 1;
    localparam int          STAT_BUSY  = 2;
    localparam int          STAT_CHAN  = 8;

    typedef enum logic [1:0] {
        CBC_IDLE = 2'b00,
        CBC_RUN  = 2'b01,
        CBC_SYNC = 2'b11
    } cbc_gen_t;

    // ****************************************
    // byte slot helpers
    // ****************************************
    // byte index is address / 8; word 0 never carries protection
    function automatic logic cbc_is_data(input logic [4:0] b);
        return !b[1] && (b[4:2] != 3'h0);
    endfunction

    function automatic logic cbc_is_chk(input logic [4:0] b);
        return b[1] && (b[4:2] != 3'h0);
    endfunction

    // protected slot number 0..13, same for a data byte and its check byte
    function automatic logic [3:0] cbc_idx(input logic [4:0] b);
        logic [2:0] w;
        w = b[4:2] - 3'h1;
        return {w, b[0]};
    endfunction

    // address code in the upper nibble, inverted channel xor direction below
    function automatic logic [7:0] cbc_enc(input logic [3:0] idx,
                                           input logic [3:0] chan,
                                           input logic [3:0] dir);
        return {idx + 4'h1, ~chan ^ dir};
    endfunction
endpackage

// ==== common/cbc_if.sv ====
// bus timing strobes shared between the clock generator and the host core
// assumes both ends run on the same system clock
`timescale 1ns/100ps
interface cbc_if;
    logic       rise;
    logic       fall;
    logic       frame_start;
    logic       frame_end;
    logic       busy;
    logic [7:0] addr;

    modport gen (output rise, fall, frame_start, frame_end, busy, addr);
    modport core (input rise, fall, frame_start, frame_end, busy, addr);
endinterface

// ==== logic/cbc_codec.sv ====
// check byte former: data xor encoding byte
// assumes caller supplies slot number, channel and direction of the frame
`timescale 1ns/100ps
module cbc_codec (
    // operands
    input  wire logic [7:0] d,
    input  wire logic [3:0] idx,
    input  wire logic [3:0] chan,
    input  wire logic [3:0] dir,
    // result
    output logic      [7:0] chk
);
    import cbc_pkg::*;

    // the same xor both forms and undoes the check byte
    assign chk = d ^ cbc_enc(idx, chan, dir);
endmodule

// ==== logic/cbc_clkgen.sv ====
// bus clock divider and frame sequencer
// assumes the bus clock is made here; it idles low during sync and halt
`timescale 1ns/100ps
module cbc_clkgen #(
    parameter int HALF_CYCLES = cbc_pkg::HALF_CYC,
    parameter int SYNC_CYCLES = cbc_pkg::SYNC_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic run,
    // bus clock pin
    output logic      bus_clk_o,
    // strobes to the core
    cbc_if.gen        tim
);
    import cbc_pkg::*;

    localparam int CW = $clog2(HALF_CYCLES + SYNC_CYCLES + 1);

    // sampling two cycles after the fall needs a half period of three
    if (HALF_CYCLES < 3 || SYNC_CYCLES < 1) begin : g_bad_param
        $error("cbc_clkgen: half period below 3 or empty sync");
    end

    cbc_gen_t      st_q;
    logic [CW-1:0] cnt_q;
    logic [7:0]    addr_q;
    logic          clk_q;
    logic          rise_q;
    logic          fall_q;
    logic          end_q;

    // ****************************************
    // sequencer
    // ****************************************
    // edges and strobes leave the same flops so they stay aligned
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q   <= CBC_IDLE;
            cnt_q  <= '0;
            addr_q <= ADDR_FIRST;
            clk_q  <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            end_q  <= 1'b0;
        end else begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            end_q  <= 1'b0;
            unique case (st_q)
                CBC_IDLE, CBC_SYNC: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - CW'(1);
                    end else if (run) begin
                        st_q   <= CBC_RUN;
                        clk_q  <= 1'b1;
                        rise_q <= 1'b1;
                        addr_q <= ADDR_FIRST;
                        cnt_q  <= CW'(HALF_CYCLES - 1);
                    end else begin
                        st_q <= CBC_IDLE;
                    end
                end
                CBC_RUN: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - CW'(1);
                    end else if (clk_q) begin
                        clk_q  <= 1'b0;
                        fall_q <= 1'b1;
                        cnt_q  <= CW'(HALF_CYCLES - 1);
                    end else if (addr_q == ADDR_LAST) begin
                        st_q  <= CBC_SYNC;
                        end_q <= 1'b1;
                        cnt_q <= CW'(SYNC_CYCLES - 1);
                    end else begin
                        addr_q <= addr_q + 8'h01;
                        clk_q  <= 1'b1;
                        rise_q <= 1'b1;
                        cnt_q  <= CW'(HALF_CYCLES - 1);
                    end
                end
                default: st_q <= CBC_IDLE;
            endcase
        end
    end

    assign bus_clk_o       = clk_q;
    assign tim.rise        = rise_q;
    assign tim.fall        = fall_q;
    assign tim.frame_end   = end_q;
    assign tim.frame_start = rise_q && (addr_q == ADDR_FIRST);
    assign tim.busy        = (st_q == CBC_RUN);
    assign tim.addr        = addr_q;
endmodule

// ==== test/cbc_dev.sv ====
// bus device model: one input device sending two checked bytes
// assumes the host bus clock idles low between frames; in line active low
`timescale 1ns/100ps
module cbc_dev (
    // bus pins
    input  wire logic bus_clk,
    input  wire logic out_oe,
    output logic      in_n
);
    logic [7:0] a  = 8'hFF;
    logic [3:0] ch = 4'h0;
    logic [7:0] d0, d1, c0, c1;
    logic       b;
    int         f  = -1;
    initial in_n = 1'b1;
    // odd frames carry a corrupt check byte and raise the error input
    always @(posedge bus_clk) begin
        a = a + 8'h01;
        if (a == 8'h00) f++;
        d0 = 8'h5A ^ {8{f[0]}};
        d1 = d0 ^ 8'h0F;
        c0 = d0 ^ {4'h1, ~ch} ^ {7'h00, f[0]};
        c1 = d1 ^ {4'h2, ~ch};
        case (a[7:3])
            5'h04: b = d0[a[2:0]];
            5'h05: b = d1[a[2:0]];
            5'h06: b = c0[a[2:0]];
            5'h07: b = c1[a[2:0]];
            default: b = (a == 8'h09) && f[0];
        endcase
        in_n <= ~b;
    end
    // channel comes from this frame's broadcast, sampled on the fall
    always @(negedge bus_clk) begin
        if (a >= 8'h01 && a <= 8'h04) ch[a - 8'h01] <= out_oe;
    end
endmodule

// ==== test/tb.sv ====
// top bench: register tasks drive the host, a device model answers
// assumes shortened divider and sync counts for a quick run
`timescale 1ns/100ps
module tb;
    import cbc_pkg::*;
    logic         clk       = 1'b0;
    logic         rst       = 1'b1;
    logic [8:0]   reg_addr  = 9'h000;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_wr    = 1'b0;
    logic         reg_rd    = 1'b0;
    logic [31:0]  reg_rdata, rd;
    logic         bus_clk, oe, in_n, od;
    logic [255:0] line;
    logic [7:0]   pos       = 8'hFF;
    int           fail_count = 0;
    int           checks     = 0;
    always #10 clk = ~clk;
    cbc_host #(.HALF_CYCLES(3), .SYNC_CYCLES(5)) cbc_host_i (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bus_clk_o(bus_clk), .out_line_o(od), .out_line_oe(oe),
        .in_line_i(in_n));
    cbc_dev cbc_dev_i (.bus_clk(bus_clk), .out_oe(oe), .in_n(in_n));
    // record the host's bits where devices sample them
    always @(posedge bus_clk) pos <= pos + 8'h01;
    always @(negedge bus_clk) line[pos] <= oe;
    // ****************************************
    // register access and compare
    // ****************************************
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [8:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rr(input logic [8:0] a);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rd = reg_rdata;
    endtask
    task rdc(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
        rr(a);
        chk(rd & m, e);
    endtask
    task close_out;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // poll for frame done under a bound, then clear it
    task wait_done;
        int n;
        for (n = 0; n < 3000; n++) begin
            rr(REG_STAT);
            if (rd[STAT_DONE] === 1'b1) break;
        end
        if (n == 3000) begin
            fail_count++;
            close_out;
        end else begin
            wr(REG_STAT, 32'h2);
        end
    endtask
    // three frames: first good, second with a bad check on a paired word, third good with auto channel stepping
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wr(REG_CHAN, 32'h3);
        wr(REG_CHK_EN, 32'h3);
        wr(REG_PAIR, 32'h1);
        wr(9'h088, 32'h81);
        wr(9'h090, 32'hA3);
        wr(REG_CTRL, 32'h1);
        wait_done;
        chk(32'(line[15:0]), 32'h0186);
        chk(32'(od), 32'h0);
        chk(32'(line[23:16]), 32'h81);
        chk(32'(line[39:32]), 32'hA3);
        chk(32'(line[63:48]), 32'h24B7);
        rdc(9'h110, 32'hFF, 32'h5A);
        rdc(9'h114, 32'hFF, 32'h55);
        rdc(REG_REJ, 32'h3FFF, 32'h0);
        rdc(REG_STAT, 32'h1, 32'h0);
        rdc(REG_STAT, 32'hF00, 32'h300);
        wait_done;
        rdc(9'h110, 32'hFF, 32'h5A);
        rdc(9'h114, 32'hFF, 32'h55);
        rdc(REG_REJ, 32'h3FFF, 32'h3);
        rdc(REG_STAT, 32'h1, 32'h1);
        wr(REG_REJ, 32'h1);
        rdc(REG_REJ, 32'h3FFF, 32'h2);
        wr(REG_STAT, 32'h1);
        rdc(REG_STAT, 32'h1, 32'h0);
        wr(REG_CTRL, 32'h3);
        wait_done;
        rdc(REG_CHAN, 32'hF, 32'h4);
        rdc(REG_REJ, 32'h3FFF, 32'h2);
        rdc(9'h110, 32'hFF, 32'h5A);
        rdc(9'h1FC, 32'hFFFFFFFF, 32'h0);
        rdc(9'h002, 32'hFFFFFFFF, 32'h0);
        close_out;
    end
endmodule
